// ===== src/pow_loader.sv
// Functional notes
// [R1] bit 4 low disables hold/reset function of the shared data line three
// [R2] bit 3 low starts four-line io protocol at next power-on
// [R3] bit 2 low starts two-line io protocol at next power-on
// [R4] both bits 3 and 2 low: four-line protocol wins
// [R5] bit 1 picks 128Mb half for 3-byte mode: 0 upper, 1 bottom
// [R6] bit 0 low gives 4-byte addresses, high gives 3-byte addresses
// [R7] bits 15:12 give default fast-read dummy count 1 to 15
// [R8] default dummy setting is safe at the 108 MHz maximum
// [R9] host must set enough dummy cycles for its clock rate
// [R10] host picks dummy per read type: 4 single, 10 four-line io
// [R11] bits 11:9 pick execute-in-place mode entered at power-on
// [R12] default bits 11:9 start extended protocol, execute-in-place off
// [R13] bits 8:6 give output driver strength, default 30 ohms
// [R14] dummy field 0000 acts as 1111
// [R15] stored word only sampled at power-on; later writes wait
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module pow_loader
  import pow_pkg::*;
(
  // system
  input  wire logic              clock,
  input  wire logic              rst_n,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  // pins
  input  wire logic              power_on_pin,
  input  wire logic              data_line_three_in,
  // applied settings
  output logic                   settings_valid,
  output logic      [3:0]        dummy_cycles,
  output logic                   execute_in_place_mode,
  output pow_xip_t               xip_kind,
  output logic      [2:0]        drive_strength,
  output logic                   hold_enable,
  output logic                   hold_asserted,
  output pow_proto_t             protocol,
  output logic                   bottom_segment,
  output logic                   four_byte_addr
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pins_raw;
  logic [1:0] pins_sync;
  logic       por_sync;
  logic       dl3_sync;

  assign pins_raw = {power_on_pin, data_line_three_in};

  pow_sync #(
    .W (2)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (pins_raw),
    .q     (pins_sync)
  );

  assign por_sync = pins_sync[1];
  assign dl3_sync = pins_sync[0];

  logic por_prev_ff;
  logic por_rise;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      por_prev_ff <= 1'b1;
    end else begin
      por_prev_ff <= por_sync;
    end
  end

  // a rising power-on pin stands for a fresh power-up
  assign por_rise = por_sync & ~por_prev_ff;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic sel_word;
  logic sel_applied;
  logic sel_status;
  logic sel_dummy;
  logic word_wr;

  assign sel_word    = (addr == OFF_WORD);
  assign sel_applied = (addr == OFF_APPLIED);
  assign sel_status  = (addr == OFF_STATUS);
  assign sel_dummy   = (addr == OFF_DUMMY);
  assign word_wr     = wr_en & sel_word;

  // ----------------------------------------------------------------
  // stored settings word
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] stored_word;

  pow_store u_store (
    .clock (clock),
    .rst_n (rst_n),
    .wr_en (word_wr),
    .wdata (wdata),
    .rdata (stored_word)
  );

  // ----------------------------------------------------------------
  // power-on sequence
  // ----------------------------------------------------------------
  localparam logic [2:0] LOAD_LAST = 3'(LOAD_CYC - 1);

  pow_state_t state_ff;
  pow_state_t nxt_state;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic       capture;

  // the wait lets a write landing just before the sequence settle
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    capture   = 1'b0;
    case (state_ff)
      POW_ST_INIT: begin
        nxt_state = POW_ST_LOAD;
        nxt_cnt   = 3'h0;
      end
      POW_ST_LOAD: begin
        if (cnt_ff == LOAD_LAST) begin
          capture   = 1'b1;
          nxt_state = POW_ST_RUN;
        end else begin
          nxt_cnt = cnt_ff + 3'h1;
        end
      end
      POW_ST_RUN: begin
        if (por_rise) begin
          nxt_state = POW_ST_LOAD;
          nxt_cnt   = 3'h0;
        end
      end
      default: begin
        nxt_state = POW_ST_INIT;
        nxt_cnt   = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= POW_ST_INIT;
      cnt_ff   <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // field decode of the sampled word
  // ----------------------------------------------------------------
  logic [3:0] raw_dummy;
  logic [2:0] raw_xip;
  logic       xip_legal;
  logic       quad_req;
  logic       dual_req;
  logic [3:0] nxt_dummy;
  pow_xip_t   nxt_xip;
  pow_proto_t nxt_proto;

  assign raw_dummy = stored_word[DUMMY_MSB:DUMMY_LSB];  // [R7]
  assign raw_xip   = stored_word[XIP_MSB:XIP_LSB];      // [R11]

  // zero would mean no dummy at all; the slowest safe count is used
  assign nxt_dummy = (raw_dummy == DUMMY_ZERO) ? DUMMY_MAX
                                               : raw_dummy;  // [R14] [R8]

  // reserved codes fall back to execute-in-place off
  assign xip_legal = (raw_xip <= 3'(POW_XIP_FOUR_IO));
  assign nxt_xip   = xip_legal ? pow_xip_t'(raw_xip)
                               : POW_XIP_OFF;  // [R12]

  assign quad_req = ~stored_word[QUAD_BIT];  // [R2]
  assign dual_req = ~stored_word[DUAL_BIT];  // [R3]

  // four-line request checked first so it wins a tie
  assign nxt_proto = quad_req ? POW_PROTO_FOUR :
                     dual_req ? POW_PROTO_TWO  :
                                POW_PROTO_EXT;  // [R4]

  // ----------------------------------------------------------------
  // applied settings, changed only by a capture; valid_ff follows the sequence state
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] applied_ff;
  logic [3:0]        dummy_ff;
  pow_xip_t          xip_ff;
  logic [2:0]        drv_ff;
  logic              hold_en_ff;
  pow_proto_t        proto_ff;
  logic              seg_ff;
  logic              addr4_ff;
  logic              valid_ff;
  logic              nxt_valid;
  logic              nxt_hold_en;
  logic              nxt_four;

  // next-cycle view, so hold never outlives valid or its enable
  assign nxt_valid   = (nxt_state == POW_ST_RUN);
  assign nxt_hold_en = capture ? stored_word[HOLD_BIT] : hold_en_ff;
  assign nxt_four    = capture ? (nxt_proto == POW_PROTO_FOUR)
                               : (proto_ff == POW_PROTO_FOUR);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      applied_ff <= WORD_RST;
      valid_ff   <= 1'b0;
    end else begin
      if (capture) begin
        applied_ff <= stored_word;  // [R15]
      end
      valid_ff <= nxt_valid;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dummy_ff <= DUMMY_MAX;
    end else if (capture) begin
      dummy_ff <= nxt_dummy;  // [R7]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      xip_ff <= POW_XIP_OFF;
    end else if (capture) begin
      xip_ff <= nxt_xip;  // [R11]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      drv_ff <= WORD_RST[DRV_MSB:DRV_LSB];
    end else if (capture) begin
      drv_ff <= stored_word[DRV_MSB:DRV_LSB];  // [R13]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_en_ff <= WORD_RST[HOLD_BIT];
    end else if (capture) begin
      hold_en_ff <= stored_word[HOLD_BIT];  // [R1]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      proto_ff <= POW_PROTO_EXT;
    end else if (capture) begin
      proto_ff <= nxt_proto;  // [R2] [R3]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seg_ff <= WORD_RST[SEG_BIT];
    end else if (capture) begin
      seg_ff <= stored_word[SEG_BIT];  // [R5]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      addr4_ff <= ~WORD_RST[ADDR_BIT];
    end else if (capture) begin
      addr4_ff <= ~stored_word[ADDR_BIT];  // [R6]
    end
  end

  // ----------------------------------------------------------------
  // hold/reset function on data line three
  // ----------------------------------------------------------------
  logic hold_ff;

  // in four-line protocol the pin carries data, so no hold is seen
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold_en & nxt_valid & ~dl3_sync
                 & ~nxt_four;  // [R1]
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] dummy_word;
  logic              change_pending;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_ff;

  // a write after the sequence shows here until the next power-on
  assign change_pending = (stored_word != applied_ff);  // [R15]

  assign status_word = {11'h000, change_pending,
                        (xip_ff != POW_XIP_OFF),
                        proto_ff, valid_ff};
  assign dummy_word  = {12'h000, dummy_ff};

  assign rd_mux = sel_word    ? stored_word :
                  sel_applied ? applied_ff  :
                  sel_status  ? status_word :
                  sel_dummy   ? dummy_word  :
                                16'h0000;

  // read data stand one cycle only; zero otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= rd_en ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata                 = rdata_ff;
  assign settings_valid        = valid_ff;
  assign dummy_cycles          = dummy_ff;
  assign xip_kind              = xip_ff;
  assign execute_in_place_mode = (xip_ff != POW_XIP_OFF);  // [R11] [R12]
  assign drive_strength        = drv_ff;
  assign hold_enable           = hold_en_ff;
  assign hold_asserted         = hold_ff;
  assign protocol              = proto_ff;
  assign bottom_segment        = seg_ff;
  assign four_byte_addr        = addr4_ff;

endmodule : pow_loader

// ===== src/pow_pkg.sv
package pow_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam int          DATA_W      = 16;
  localparam logic [3:0]  OFF_WORD    = 4'h0;
  localparam logic [3:0]  OFF_APPLIED = 4'h1;
  localparam logic [3:0]  OFF_STATUS  = 4'h2;
  localparam logic [3:0]  OFF_DUMMY   = 4'h3;

  // ----------------------------------------------------------------
  // power-on settings word layout
  // ----------------------------------------------------------------
  localparam int          DUMMY_MSB   = 15;
  localparam int          DUMMY_LSB   = 12;
  localparam int          XIP_MSB     = 11;
  localparam int          XIP_LSB     = 9;
  localparam int          DRV_MSB     = 8;
  localparam int          DRV_LSB     = 6;
  localparam int          HOLD_BIT    = 4;
  localparam int          QUAD_BIT    = 3;
  localparam int          DUAL_BIT    = 2;
  localparam int          SEG_BIT     = 1;
  localparam int          ADDR_BIT    = 0;
  localparam logic [15:0] WORD_RST    = 16'hffff;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [3:0]  DUMMY_ZERO  = 4'h0;
  localparam logic [3:0]  DUMMY_MAX   = 4'hf;

  typedef enum logic [2:0] {
    POW_XIP_SINGLE   = 3'b000,
    POW_XIP_TWO_OUT  = 3'b001,
    POW_XIP_TWO_IO   = 3'b010,
    POW_XIP_FOUR_OUT = 3'b011,
    POW_XIP_FOUR_IO  = 3'b100,
    POW_XIP_OFF      = 3'b111
  } pow_xip_t;

  typedef enum logic [1:0] {
    POW_PROTO_EXT  = 2'b00,
    POW_PROTO_TWO  = 2'b01,
    POW_PROTO_FOUR = 2'b10
  } pow_proto_t;

  typedef enum logic [1:0] {
    POW_ST_INIT = 2'b00,
    POW_ST_LOAD = 2'b01,
    POW_ST_RUN  = 2'b10
  } pow_state_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_NS      = 50;
  localparam int          LOAD_NS     = 100;
  localparam int          LOAD_CYC    = (LOAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SYNC_STAGES = 2;

endpackage : pow_pkg

// ===== src/pow_sync.sv
`timescale 1ns/1ps
module pow_sync #(
  parameter int W = 1
) (
  // system
  input  wire logic         clock,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '1;
      q_ff    <= '1;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : pow_sync

// ===== src/pow_store.sv
`timescale 1ns/1ps
module pow_store
  import pow_pkg::*;
(
  // system
  input  wire logic              clock,
  input  wire logic              rst_n,
  // write side
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wdata,
  // registered read data
  output logic      [DATA_W-1:0] rdata
);

  logic [DATA_W-1:0] word_ff;
  logic [DATA_W-1:0] rdata_ff;

  // reset stands for the delivered state of the stored word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      word_ff  <= WORD_RST;
      rdata_ff <= WORD_RST;
    end else begin
      if (wr_en) begin
        word_ff <= wdata;
      end
      rdata_ff <= word_ff;
    end
  end

  assign rdata = rdata_ff;

endmodule : pow_store

// ===== test/pow_host.sv
`timescale 1ns/1ps
module pow_host (
  // system
  input  wire logic       clock,
  input  wire logic       rst_n,
  // bench requests
  input  wire logic       pwr_req,
  input  wire logic       hold_req,
  // pins toward the device
  output logic            power_on_pin,
  output logic            data_line_three_in,
  // dummy counts the host picks for 108 MHz
  output logic      [3:0] min_single,
  output logic      [3:0] min_four_io
);
  logic [2:0] pwr_ff;

  // pin stays up several cycles so the synchroniser cannot miss it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) pwr_ff <= 3'h0;
    else if (pwr_req) pwr_ff <= 3'h4;
    else if (pwr_ff != 3'h0) pwr_ff <= pwr_ff - 3'h1;
  end
  assign power_on_pin       = (pwr_ff != 3'h0);
  // pulled up, so a released line reads high
  assign data_line_three_in = !hold_req;
  assign min_single         = 4'h4;
  assign min_four_io        = 4'ha;
endmodule : pow_host

// ===== test/pow_loader_checker.sv
`timescale 1ns/1ps
module pow_loader_checker
  import pow_pkg::*;
(
  // system
  input wire logic        clock,
  input wire logic        rst_n,
  // register port
  input wire logic [3:0]  addr,
  input wire logic        rd_en,
  input wire logic [15:0] rdata,
  // pins and settings
  input wire logic        data_line_three_in,
  input wire logic        settings_valid,
  input wire logic [3:0]  dummy_cycles,
  input wire logic        execute_in_place_mode,
  input pow_xip_t         xip_kind,
  input wire logic [2:0]  drive_strength,
  input wire logic        hold_enable,
  input wire logic        hold_asserted,
  input pow_proto_t       protocol,
  input wire logic        bottom_segment,
  input wire logic        four_byte_addr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_dummy_nonzero: assert property (dummy_cycles != 4'h0)
    else $error("dummy count is zero");
  chk_xip_flag: assert property (
    execute_in_place_mode == (xip_kind != POW_XIP_OFF))
    else $error("xip flag disagrees with kind");
  chk_xip_legal: assert property (!(xip_kind inside {3'b101, 3'b110}))
    else $error("reserved xip kind applied");
  chk_hold_gate: assert property (hold_asserted |-> hold_enable &&
    settings_valid && protocol != POW_PROTO_FOUR)
    else $error("hold asserted while gated off");
  chk_hold_rise: assert property ((settings_valid && hold_enable &&
    protocol != POW_PROTO_FOUR && !data_line_three_in) [*4]
    |-> ##[0:1] hold_asserted)
    else $error("hold request not seen");
  chk_steady_set: assert property (
    settings_valid && $past(settings_valid) |-> $stable({dummy_cycles,
    xip_kind, drive_strength, hold_enable, protocol, bottom_segment,
    four_byte_addr}))
    else $error("settings moved outside power-on");
  chk_reload_time: assert property (
    $fell(settings_valid) |-> ##[1:4] settings_valid)
    else $error("reload too long");
  chk_dummy_read: assert property (rd_en && addr == OFF_DUMMY
    |=> rdata[3:0] == $past(dummy_cycles))
    else $error("dummy register read wrong");
  chk_status_read: assert property (rd_en && addr == OFF_STATUS
    |=> rdata[2:0] == {$past(protocol), $past(settings_valid)})
    else $error("status read wrong");

  cov_hold: cover property (hold_asserted);
  cov_four: cover property (settings_valid && protocol == POW_PROTO_FOUR);
  cov_reload: cover property ($fell(settings_valid));
endmodule : pow_loader_checker

// ===== test/tb_pow_loader.sv
`timescale 1ns/1ps
module tb_pow_loader;
  import pow_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        pwr_req = 1'b0;
  logic        hold_req = 1'b0;
  logic [15:0] rdata, w, d, applied;
  logic        power_on_pin, data_line_three_in, settings_valid;
  logic        execute_in_place_mode, hold_enable, hold_asserted;
  logic        bottom_segment, four_byte_addr;
  logic [3:0]  dummy_cycles, min_single, min_four_io;
  logic [2:0]  drive_strength;
  pow_xip_t    xip_kind;
  pow_proto_t  protocol;
  logic [15:0] words[$];
  int          err_count = 0;
  int          compares = 0;

  always #25 clock = ~clock;

  pow_loader i_dut (.clock(clock), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .power_on_pin(power_on_pin), .data_line_three_in(data_line_three_in),
    .settings_valid(settings_valid), .dummy_cycles(dummy_cycles),
    .execute_in_place_mode(execute_in_place_mode), .xip_kind(xip_kind),
    .drive_strength(drive_strength), .hold_enable(hold_enable),
    .hold_asserted(hold_asserted), .protocol(protocol),
    .bottom_segment(bottom_segment), .four_byte_addr(four_byte_addr));
  pow_host i_host (.clock(clock), .rst_n(rst_n), .pwr_req(pwr_req),
    .hold_req(hold_req), .power_on_pin(power_on_pin),
    .data_line_three_in(data_line_three_in), .min_single(min_single),
    .min_four_io(min_four_io));

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    v = rdata;
  endtask : rd

  task automatic wait_valid(input logic lvl);
    int n;
    n = 0;
    while (settings_valid !== lvl && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("settings_valid", settings_valid, lvl);
  endtask : wait_valid

  task automatic power_cycle;
    @(posedge clock);
    pwr_req <= 1'b1;
    @(posedge clock);
    pwr_req <= 1'b0;
    wait_valid(1'b0);
    wait_valid(1'b1);
  endtask : power_cycle

  // expectations come from the word alone, never from the design
  task automatic check_settings(input logic [15:0] v);
    logic [2:0]  x;
    logic [1:0]  p;
    logic [3:0]  dm;
    logic [15:0] r;
    x = (v[11:9] > 3'h4) ? 3'h7 : v[11:9];
    p = !v[3] ? 2'h2 : (!v[2] ? 2'h1 : 2'h0);
    dm = (v[15:12] == 4'h0) ? 4'hf : v[15:12];
    check("dummy", dummy_cycles, dm);
    check("xip_kind", xip_kind, x);
    check("xip_on", execute_in_place_mode, x != 3'h7);
    check("drive", drive_strength, v[8:6]);
    check("hold_en", hold_enable, v[4]);
    check("protocol", protocol, p);
    check("segment", bottom_segment, v[1]);
    check("addr4", four_byte_addr, !v[0]);
    rd(OFF_DUMMY, r);
    check("dummy_reg", r, dm);
    rd(OFF_APPLIED, r);
    check("applied", r, v);
    rd(OFF_STATUS, r);
    check("status", r[3:0], {x != 3'h7, p, 1'b1});
    @(posedge clock);
    hold_req <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    check("hold", hold_asserted, v[4] && p != 2'h2);
    @(posedge clock);
    hold_req <= 1'b0;
  endtask : check_settings

  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hb0cf));
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    wait_valid(1'b1);
    applied = WORD_RST;
    check_settings(applied);
    $display("test defaults done");
    for (int i = 0; i < 8; i++) begin
      w = 16'($urandom);
      w[11:9] = 3'(i);
      w[3:2] = 2'(i);
      if (i == 0) w[15:12] = 4'h0;
      if (i == 1) w[15:12] = min_single;
      if (i == 2) w[15:12] = min_four_io;
      words.push_back(w);
    end
    foreach (words[i]) begin
      wr(OFF_WORD, words[i]);
      rd(OFF_WORD, d);
      check("stored", d, words[i]);
      rd(OFF_STATUS, d);
      check("pending", d[4], words[i] != applied);
      check_settings(applied);
      power_cycle();
      applied = words[i];
      check_settings(applied);
      $display("test word %0d done", i);
    end
    wr(OFF_APPLIED, 16'h0);
    rd(4'h9, d);
    check("unmapped", d, 16'h0);
    // read data stand one cycle only, then fall back to zero
    @(posedge clock);
    #1;
    check("rdata_idle", rdata, 16'h0);
    rd(OFF_APPLIED, d);
    check("applied_ro", d, applied);
    $display("test access done");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    wait_valid(1'b1);
    check_settings(WORD_RST);
    rd(OFF_WORD, d);
    check("stored_rst", d, WORD_RST);
    $display("test reset done");
    conclude();
  end

  // a stuck handshake ends the run here
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    $display("ERROR watchdog exp finish seen hang");
    conclude();
  end
endmodule : tb_pow_loader

bind pow_loader pow_loader_checker i_chk (.clock(clock), .rst_n(rst_n),
  .addr(addr), .rd_en(rd_en), .rdata(rdata),
  .data_line_three_in(data_line_three_in),
  .settings_valid(settings_valid), .dummy_cycles(dummy_cycles),
  .execute_in_place_mode(execute_in_place_mode), .xip_kind(xip_kind),
  .drive_strength(drive_strength), .hold_enable(hold_enable),
  .hold_asserted(hold_asserted), .protocol(protocol),
  .bottom_segment(bottom_segment), .four_byte_addr(four_byte_addr));
